/* logic/trace_defs.svh */
// Offsets, field positions, reset values and timing counts of the trace trigger unit
`ifndef TRACE_DEFS_SVH
`define TRACE_DEFS_SVH
// Staging buffer
`define STG_DEPTH      4'h8
`define STG_OVF_LEVEL  4'h7
// Timestamp: 8.333 ns resolution, at least 27 days of range
`define TS_RES_PS      32'h0000_208D
`define CLK_PS         32'h0000_0FA0
`define TS_RANGE_DAYS  32'h0000_001B
`define TS_W           48
// Trigger pulse: microsecond tick derived from the clock period
`define US_NS          32'h0000_03E8
`define CLK_NS         32'h0000_0004
`define US_CYCLES      (`US_NS / `CLK_NS)
`define PULSE_MIN_US   16'h0001
`define PULSE_MAX_US   16'hFFFF
// Trace memory capacity in records
`define MEM_WORDS      16'h0400
// Register byte addresses
`define REG_CTRL       32'h0000_0000
`define REG_TRIG       32'h0000_0004
`define REG_PULSE0     32'h0000_0008
`define REG_PULSE1     32'h0000_000C
`define REG_STATUS     32'h0000_0010
`define REG_IRQ_EN     32'h0000_0014
`define REG_IRQ_CLR    32'h0000_0018
`define REG_FILL       32'h0000_001C
`define REG_PRES_SET   32'h0000_0020
`define REG_PRESENCE   32'hFF0B_0160
// Control fields
`define CTRL_EN        0
`define CTRL_SYNC      1
`define CTRL_TIMER     2
`define CTRL_CONN      3
`define CTRL_CPU_LO    4
`define CTRL_RT        7
`define CTRL_MODE_LO   8
`define CTRL_MEMCLR    10
`define CTRL_RESET     32'h0000_0000
`define MODE_RING      2'h0
`define MODE_STOP      2'h1
`define MODE_BREAK     2'h2
// Trigger modes, four bits per channel, action bit 3 set stops recording when capture is not allowed, otherwise the trigger breaks
`define TRG_RISE       3'h0
`define TRG_FALL       3'h1
`define TRG_BOTH       3'h2
`define TRG_LOW        3'h3
`define TRG_HIGH       3'h4
`define PULSE_POL      16
// Status bits
`define ST_OVF         0
`define ST_TRIG0       1
`define ST_FULL        3
`define ST_BREAK       4
`endif

/* logic/trace_pkg.sv */
// Types carried by the trace trigger unit
`include "trace_defs.svh"
package trace_pkg;
  typedef struct packed {
    logic [2:0]  cpu;
    logic [1:0]  kind;
    logic [31:0] pc;
    logic [31:0] value;
  } trace_item_t;
  typedef struct packed {
    logic              ovf;
    trace_item_t       item;
    logic [`TS_W-1:0]  ts;
  } trace_rec_t;
endpackage

/* logic/software_trace_trigger_unit.sv */
// Software trace staging, timestamps, trigger detection and trigger pulses
`timescale 1ns/1ps
`include "trace_defs.svh"
module software_trace_trigger_unit (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite slave
  input  wire logic [31:0]            awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [31:0]            araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // Trace items from the debug link
  input  wire logic                   item_valid,
  input  wire trace_pkg::trace_item_t item,
  output logic                        item_ready,
  input  wire logic                   target_running,
  // Records to trace storage
  output logic                        store_valid,
  output trace_pkg::trace_rec_t       store_rec,
  input  wire logic                   store_ready,
  // Trigger pins and break
  input  wire logic [1:0]             trig_in,
  output logic [1:0]                  trig_out,
  output logic                        break_req,
  output logic                        rec_stop,
  output logic                        irq
);
  trace_pkg::trace_rec_t stage [8];
  trace_pkg::trace_rec_t wr_data;
  logic [31:0] ctrl, trig_cfg, status, irq_en, pres, aw_addr, w_data;
  logic [31:0] next_ctrl, next_trig, next_status, next_irq_en, next_pres, next_aw_addr, next_w_data;
  logic [31:0] pulse_cfg [2];
  logic [31:0] next_pulse_cfg [2];
  logic [15:0] pulse_cnt [2];
  logic [15:0] next_pulse_cnt [2];
  logic [3:0]  w_strb, next_w_strb, count, next_count;
  logic [2:0]  wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [13:0] acc, next_acc;
  logic [7:0]  us_cnt, next_us_cnt;
  logic [15:0] mem_cnt, next_mem_cnt, width;
  logic [`TS_W-1:0] ts, next_ts;
  logic [1:0]  trig_meta, trig_sync, trig_prev, det, next_trig_out;
  logic aw_held, w_held, next_aw_held, next_w_held, next_awready, next_wready;
  logic next_bvalid, next_arready, next_rvalid, next_store_valid, next_item_ready;
  logic next_break_req, next_rec_stop, next_irq, ovf_hold, next_ovf_hold, mem_stopped, next_mem_stopped;
  logic run_prev, allowed, recording, push_req, push, pop, wr_en, wr_go, us_tick, run_fall, mem_full, trig_brk;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, clr, wm;
  trace_pkg::trace_rec_t next_store_rec;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Trigger detectors, one per channel
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_trig
      always_comb begin
        case (trig_cfg[4*g +: 3])
          `TRG_RISE: det[g] = trig_sync[g] & ~trig_prev[g];
          `TRG_FALL: det[g] = ~trig_sync[g] & trig_prev[g];
          `TRG_BOTH: det[g] = trig_sync[g] ^ trig_prev[g];
          `TRG_LOW:  det[g] = ~trig_sync[g];
          `TRG_HIGH: det[g] = trig_sync[g];
          default:   det[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_comb begin
    next_ctrl = ctrl;
    next_trig = trig_cfg;
    next_pulse_cfg = pulse_cfg;
    next_irq_en = irq_en;
    next_pres = pres;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_bvalid = bvalid & ~bready;
    next_bresp = bresp;
    next_rvalid = rvalid & ~rready;
    next_rdata = rdata;
    next_rresp = rresp;
    clr = 32'h0000_0000;
    wm = merge(ctrl, w_data, w_strb);
    // Timestamp at 8.333 ns from a fractional accumulator
    next_acc = acc + 14'(`CLK_PS);
    next_ts = ts;
    if (next_acc >= 14'(`TS_RES_PS)) begin
      next_acc = next_acc - 14'(`TS_RES_PS);
      next_ts = ts + 1'b1;
    end
    us_tick = (us_cnt == 8'(`US_CYCLES - 1));
    next_us_cnt = us_tick ? 8'h00 : us_cnt + 8'h01;
    // Write channel
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    wr_go = aw_held & w_held & ~bvalid;
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'h0;
      case (aw_addr)
        `REG_CTRL: begin
          next_ctrl = wm;
          next_ctrl[`CTRL_MEMCLR] = 1'b0;
          if (ctrl[`CTRL_CONN]) begin
            next_ctrl[`CTRL_CPU_LO +: 3] = ctrl[`CTRL_CPU_LO +: 3];
          end
        end
        `REG_TRIG:     next_trig = merge(trig_cfg, w_data, w_strb);
        `REG_PULSE0:   next_pulse_cfg[0] = merge(pulse_cfg[0], w_data, w_strb);
        `REG_PULSE1:   next_pulse_cfg[1] = merge(pulse_cfg[1], w_data, w_strb);
        `REG_IRQ_EN:   next_irq_en = merge(irq_en, w_data, w_strb);
        `REG_IRQ_CLR:  clr = merge(32'h0000_0000, w_data, w_strb);
        `REG_PRES_SET: next_pres = merge(pres, w_data, w_strb);
        default:       next_bresp = 2'h2;
      endcase
    end
    next_awready = ~next_aw_held;
    next_wready = ~next_w_held;
    // Read channel
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = 2'h0;
      case (araddr)
        `REG_CTRL:     next_rdata = ctrl;
        `REG_TRIG:     next_rdata = trig_cfg;
        `REG_PULSE0:   next_rdata = pulse_cfg[0];
        `REG_PULSE1:   next_rdata = pulse_cfg[1];
        `REG_STATUS:   next_rdata = status;
        `REG_IRQ_EN:   next_rdata = irq_en;
        `REG_FILL:     next_rdata = {mem_cnt, 11'h000, recording, count};
        `REG_PRESENCE: next_rdata = ctrl[`CTRL_CONN] ? pres : 32'h0000_0000;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'h2;
        end
      endcase
    end
    next_arready = ~next_rvalid;
    // Capture gating
    allowed = ctrl[`CTRL_EN] & ctrl[`CTRL_SYNC] & ~ctrl[`CTRL_TIMER] & ctrl[`CTRL_CONN];
    recording = allowed & target_running & ~mem_stopped;
    push_req = item_valid & item_ready & recording & (item.cpu == ctrl[`CTRL_CPU_LO +: 3]);
    next_ovf_hold = ovf_hold & ~(count < `STG_OVF_LEVEL);
    wr_data = '{ovf: 1'b0, item: item, ts: ts};
    push = 1'b0;
    wr_en = 1'b0;
    next_status = status & ~clr;
    if (push_req && !ovf_hold) begin
      if (count < `STG_OVF_LEVEL) begin
        push = 1'b1;
      end else if (count == `STG_OVF_LEVEL) begin
        push = 1'b1;
        wr_data.ovf = 1'b1;
        next_ovf_hold = 1'b1;
        next_status[`ST_OVF] = 1'b1;
      end
    end
    wr_en = push;
    // Drain to storage
    next_mem_cnt = mem_cnt;
    next_mem_stopped = mem_stopped;
    mem_full = 1'b0;
    if (store_valid && store_ready) begin
      if (mem_cnt == `MEM_WORDS - 16'h0001) begin
        mem_full = 1'b1;
        next_status[`ST_FULL] = 1'b1;
        if (ctrl[`CTRL_MODE_LO +: 2] == `MODE_RING) begin
          next_mem_cnt = 16'h0000;
        end else begin
          next_mem_stopped = 1'b1;
        end
      end else begin
        next_mem_cnt = mem_cnt + 16'h0001;
      end
    end
    if (wm[`CTRL_MEMCLR] && wr_go && aw_addr == `REG_CTRL) begin
      next_mem_cnt = 16'h0000;
      // A full memory in the same cycle wins over the clear
      next_mem_stopped = mem_full & (ctrl[`CTRL_MODE_LO +: 2] != `MODE_RING);
    end
    pop = (count != 4'h0) & (~store_valid | store_ready) & ~mem_stopped;
    next_store_valid = pop | (store_valid & ~store_ready);
    next_store_rec = pop ? stage[rd_ptr] : store_rec;
    next_rd_ptr = rd_ptr + 3'(pop);
    next_wr_ptr = wr_ptr + 3'(push);
    next_count = count + 4'(push) - 4'(pop);
    // Real-time keeps the link open, non-real-time holds it off before overflow
    next_item_ready = ctrl[`CTRL_RT] | (next_count <= `STG_OVF_LEVEL - 4'h2);
    // Triggers and breaks
    trig_brk = 1'b0;
    next_rec_stop = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (det[i] && target_running) begin
        next_status[`ST_TRIG0 + i] = 1'b1;
        if (allowed || !trig_cfg[4*i + 3]) begin
          trig_brk = 1'b1;
        end else begin
          next_rec_stop = 1'b1;
        end
      end
    end
    next_break_req = trig_brk | (mem_full & (ctrl[`CTRL_MODE_LO +: 2] == `MODE_BREAK));
    run_fall = run_prev & ~target_running;
    if (run_fall) begin
      next_us_cnt = 8'h00;
      next_status[`ST_BREAK] = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      width = (pulse_cfg[i][15:0] < `PULSE_MIN_US) ? `PULSE_MIN_US : pulse_cfg[i][15:0];
      next_pulse_cnt[i] = pulse_cnt[i];
      if (run_fall) begin
        next_pulse_cnt[i] = width;
      end else if (us_tick && pulse_cnt[i] != 16'h0000) begin
        next_pulse_cnt[i] = pulse_cnt[i] - 16'h0001;
      end
      next_trig_out[i] = (next_pulse_cnt[i] != 16'h0000) ~^ pulse_cfg[i][`PULSE_POL];
    end
    next_irq = |(status & irq_en);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `CTRL_RESET;
      trig_cfg <= 32'h0000_0000;
      pulse_cfg <= '{32'h0000_0000, 32'h0000_0000};
      status <= 32'h0000_0000;
      irq_en <= 32'h0000_0000;
      pres <= 32'h0000_0000;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
      acc <= 14'h0000;
      ts <= '0;
      us_cnt <= 8'h00;
      count <= 4'h0;
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      ovf_hold <= 1'b0;
      mem_cnt <= 16'h0000;
      mem_stopped <= 1'b0;
      store_valid <= 1'b0;
      store_rec <= '0;
      item_ready <= 1'b0;
      trig_meta <= 2'h0;
      trig_sync <= 2'h0;
      trig_prev <= 2'h0;
      run_prev <= 1'b0;
      break_req <= 1'b0;
      rec_stop <= 1'b0;
      pulse_cnt <= '{16'h0000, 16'h0000};
      trig_out <= 2'h3;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      trig_cfg <= next_trig;
      pulse_cfg <= next_pulse_cfg;
      status <= next_status;
      irq_en <= next_irq_en;
      pres <= next_pres;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      acc <= next_acc;
      ts <= next_ts;
      us_cnt <= next_us_cnt;
      count <= next_count;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      ovf_hold <= next_ovf_hold;
      mem_cnt <= next_mem_cnt;
      mem_stopped <= next_mem_stopped;
      store_valid <= next_store_valid;
      store_rec <= next_store_rec;
      item_ready <= next_item_ready;
      trig_meta <= trig_in;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
      run_prev <= target_running;
      break_req <= next_break_req;
      rec_stop <= next_rec_stop;
      pulse_cnt <= next_pulse_cnt;
      trig_out <= next_trig_out;
      irq <= next_irq;
    end
  end

  // Staging memory write
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      stage[wr_ptr] <= wr_data;
    end
  end

  a_ovf_marker_slot: assert property (@(posedge aclk) disable iff (!aresetn)
    (push_req && !ovf_hold && count == 4'h7 && !pop) |=> (count == 4'h8 && ovf_hold))
    else $error("overflow marker not placed in eighth stage");
  a_stage_limit: assert property (@(posedge aclk) disable iff (!aresetn) count <= `STG_DEPTH)
    else $error("staging fill above eight");
  a_drop_held: assert property (@(posedge aclk) disable iff (!aresetn)
    (ovf_hold && count >= 4'h7) |-> !push)
    else $error("item taken while overflow held");
  a_one_stage: assert property (@(posedge aclk) disable iff (!aresetn)
    (push && !pop) |=> (count == $past(count) + 4'h1))
    else $error("item did not take exactly one stage");
  a_ts_step: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(ts) |=> $stable(ts))
    else $error("timestamp stepped faster than its resolution");
  a_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl[`CTRL_TIMER] || !ctrl[`CTRL_SYNC]) |-> !push)
    else $error("capture outside synchronous mode");
  a_cpu_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl[`CTRL_CONN] && $past(ctrl[`CTRL_CONN])) |-> $stable(ctrl[`CTRL_CPU_LO +: 3]))
    else $error("traced cpu changed while connected");
  a_stop_break: assert property (@(posedge aclk) disable iff (!aresetn) !target_running |-> !push)
    else $error("capture while target stopped");
  a_rt_ready: assert property (@(posedge aclk) disable iff (!aresetn) ctrl[`CTRL_RT] |=> item_ready)
    else $error("real-time mode stalled the link");
  a_full_break: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_full && ctrl[`CTRL_MODE_LO +: 2] == `MODE_BREAK) |=> break_req ##1 mem_stopped)
    else $error("full memory did not break");
  a_trig_break: assert property (@(posedge aclk) disable iff (!aresetn)
    (det[0] && target_running && allowed) |=> (break_req && !rec_stop))
    else $error("trigger did not break while tracing");
  a_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
    run_fall |=> (trig_out[0] == pulse_cfg[0][`PULSE_POL]) [*8])
    else $error("trigger pulse not driven on break");
endmodule

/* tb/target_link_model.sv */
// Target-side model that emits software trace items over the debug link
`timescale 1ns/1ps
module target_link_model (
  // Clock and link
  input  wire logic              aclk,
  input  wire logic              present,
  input  wire logic              item_ready,
  output logic                   item_valid,
  output trace_pkg::trace_item_t item
);
  initial begin
    item_valid = 1'b0;
    item = '0;
  end
  // Hold the item until taken, then scramble the released lines
  task automatic emit(input logic [2:0] cpu, input logic [1:0] kind, input logic [31:0] pc, input logic [31:0] v);
    trace_pkg::trace_item_t it;
    it = '{cpu, kind, pc, v};
    if (present) begin
      @(posedge aclk);
      item_valid <= 1'b1;
      item <= it;
      do @(posedge aclk); while (!item_ready);
      item_valid <= 1'b0;
      item <= ~it;
    end
  endtask
  task automatic pc_item(input logic [2:0] cpu, input logic [31:0] pc);
    emit(cpu, 2'h0, pc, pc);
  endtask
  task automatic tag_item(input logic [2:0] cpu, input logic [31:0] pc, input logic [9:0] imm);
    emit(cpu, 2'h1, pc, {22'h0, imm});
  endtask
  task automatic push_items(input logic [2:0] cpu, input logic [31:0] pc, input int lo, input int hi);
    for (int r = lo; r <= hi; r++) emit(cpu, 2'h2, pc, 32'h1000_0000 + r);
  endtask
endmodule

/* tb/software_trace_trigger_unit_tb.sv */
// Testbench for the software trace trigger unit
`timescale 1ns/1ps
`include "trace_defs.svh"
module software_trace_trigger_unit_tb;
  logic                   aclk = 0, aresetn = 0;
  logic [31:0]            awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0]             wstrb = 0;
  logic                   awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic [1:0]             bresp, rresp, trig_in = 0, trig_out;
  logic                   item_valid, item_ready, target_running = 0, store_ready = 0, present = 0;
  trace_pkg::trace_item_t item;
  logic                   store_valid, break_req, rec_stop, irq;
  trace_pkg::trace_rec_t  store_rec;
  trace_pkg::trace_rec_t  recs[$];
  int                     miscompares = 0, check_count = 0, brk = 0, stp = 0, hi0 = 0, lo1 = 0;
  int                     base_brk = 0, base_stp = 0, base_hi = 0, base_lo = 0;
  logic [1:0]             br;
  logic [31:0]            v;

  always #2 aclk = ~aclk;

  software_trace_trigger_unit DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .item_valid(item_valid),
    .item(item), .item_ready(item_ready), .target_running(target_running), .store_valid(store_valid),
    .store_rec(store_rec), .store_ready(store_ready), .trig_in(trig_in), .trig_out(trig_out),
    .break_req(break_req), .rec_stop(rec_stop), .irq(irq));

  target_link_model link (.aclk(aclk), .present(present), .item_ready(item_ready),
    .item_valid(item_valid), .item(item));

  // Storage side capture and event counters
  always @(posedge aclk) begin
    if (store_valid && store_ready) recs.push_back(store_rec);
    brk <= brk + (break_req === 1'b1);
    stp <= stp + (rec_stop === 1'b1);
    hi0 <= hi0 + (trig_out[0] === 1'b1);
    lo1 <= lo1 + (trig_out[1] === 1'b0);
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (!bvalid);
    br = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [1:0] r;
    rd(a, v, r);
    chk(name, exp, v);
    chk({name, " resp"}, {30'h0, er}, {30'h0, r});
  endtask

  function automatic logic [31:0] ctrl(input logic rt, input logic [1:0] mode, input logic timer);
    return 32'h0000_001B | ({31'h0, timer} << `CTRL_TIMER) | ({31'h0, rt} << `CTRL_RT)
      | ({30'h0, mode} << `CTRL_MODE_LO);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #60000;
    miscompares++;
    summarize();
  end

  initial begin
    int n;
    logic [2:0] tm[5];
    logic [1:0] pre[5];
    tm = '{`TRG_RISE, `TRG_FALL, `TRG_BOTH, `TRG_LOW, `TRG_HIGH};
    pre = '{2'b00, 2'b11, 2'b00, 2'b11, 2'b00};
    cyc(10);
    aresetn <= 1'b1;
    cyc(2);
    // Register reset values and refusals
    rchk("presence", `REG_PRESENCE, 32'h0, 2'h0);
    wr(`REG_PRES_SET, 32'h5A5A_0001);
    chk("pres set resp", 32'h0, {30'h0, br});
    rchk("presence idle", `REG_PRESENCE, 32'h0, 2'h0);
    rchk("status", `REG_STATUS, 32'h0, 2'h0);
    rchk("unmapped", 32'h0000_0040, 32'h0, 2'h2);
    rchk("clear reg", `REG_IRQ_CLR, 32'h0, 2'h2);
    wr(32'h0000_0040, 32'hFFFF_FFFF);
    chk("unmapped wr resp", 32'h2, {30'h0, br});
    wr(`REG_CTRL, ctrl(1'b1, `MODE_RING, 1'b0));
    present <= 1'b1;
    rchk("presence conn", `REG_PRESENCE, 32'h5A5A_0001, 2'h0);
    wr(`REG_CTRL, ctrl(1'b1, `MODE_RING, 1'b0) ^ 32'h0000_0030);
    rd(`REG_CTRL, v, pre[0]);
    chk("cpu kept", 32'h1, {29'h0, v[6:4]});
    pre[0] = 2'b00;
    // Dropped items: stopped target, other CPU, timer mode
    link.pc_item(3'h1, 32'h0000_0100);
    target_running <= 1'b1;
    link.pc_item(3'h2, 32'h0000_0104);
    wr(`REG_CTRL, ctrl(1'b1, `MODE_RING, 1'b1));
    link.pc_item(3'h1, 32'h0000_0108);
    wr(`REG_CTRL, ctrl(1'b1, `MODE_RING, 1'b0));
    store_ready <= 1'b1;
    link.tag_item(3'h1, 32'h0000_0200, 10'h3FF);
    link.push_items(3'h1, 32'h0000_0204, 3, 4);
    cyc(8);
    chk("captured", 32'd3, recs.size());
    chk("tag value", 32'h0000_03FF, recs[0].item.value);
    chk("push value", 32'h1000_0004, recs[2].item.value);
    // Overflow with storage stalled in real-time mode
    store_ready <= 1'b0;
    recs.delete();
    for (int i = 0; i < 12; i++) link.pc_item(3'h1, 32'h0000_1000 + 4 * i);
    rd(`REG_FILL, v, pre[0]);
    chk("fill", 32'h8, {28'h0, v[3:0]});
    rchk("ovf status", `REG_STATUS, 32'h1, 2'h0);
    store_ready <= 1'b1;
    cyc(20);
    link.pc_item(3'h1, 32'h0000_2000);
    cyc(8);
    n = 0;
    foreach (recs[i]) n += recs[i].ovf;
    chk("markers", 32'h1, n);
    chk("marker last", 32'h1, recs[recs.size() - 2].ovf);
    chk("after drain", 32'h0000_2000, recs[recs.size() - 1].item.pc);
    // Items two cycles apart may share one tick, four cycles apart never do
    for (int i = 1; i < recs.size(); i++) chk("ts order", 32'h1, recs[i].ts >= recs[i - 1].ts);
    for (int i = 2; i < recs.size(); i++) chk("ts step", 32'h1, recs[i].ts > recs[i - 2].ts);
    // Non-real-time mode stalls the link instead of losing items
    wr(`REG_IRQ_CLR, 32'h0000_001F);
    wr(`REG_CTRL, ctrl(1'b0, `MODE_RING, 1'b0));
    store_ready <= 1'b0;
    recs.delete();
    fork
      for (int i = 0; i < 10; i++) link.pc_item(3'h1, 32'h0000_3000 + 4 * i);
      begin cyc(40); chk("link stall", 32'h0, {31'h0, item_ready}); store_ready <= 1'b1; end
    join
    cyc(20);
    chk("nrt count", 32'd10, recs.size());
    rchk("nrt status", `REG_STATUS, 32'h0, 2'h0);
    // Every trigger mode breaks while tracing, even with stop action
    for (int m = 0; m < 5; m++) begin
      trig_in <= pre[m];
      wr(`REG_TRIG, {24'h0, 1'b1, tm[m], 4'h0});
      cyc(8);
      base_brk = brk;
      trig_in <= ~pre[m];
      cyc(10);
      chk("trigger break", 32'h1, brk > base_brk);
    end
    wr(`REG_TRIG, 32'h0000_0000);
    trig_in <= 2'b01;
    cyc(8);
    base_brk = brk;
    trig_in <= 2'b00;
    cyc(10);
    chk("no rise", 32'h0, brk - base_brk);
    wr(`REG_CTRL, ctrl(1'b1, `MODE_RING, 1'b0) & ~32'h1);
    wr(`REG_TRIG, 32'h0000_0008);
    base_brk = brk;
    base_stp = stp;
    trig_in <= 2'b01;
    cyc(10);
    chk("stop rec", 32'h1, stp > base_stp);
    chk("stop no brk", 32'h0, brk - base_brk);
    // Break pulse on both outputs, interrupt raise and clear
    wr(`REG_PULSE0, 32'h0001_0002);
    wr(`REG_PULSE1, 32'h0000_0000);
    wr(`REG_IRQ_CLR, 32'h0000_001F);
    wr(`REG_IRQ_EN, 32'h0000_0010);
    base_hi = hi0;
    base_lo = lo1;
    target_running <= 1'b0;
    cyc(600);
    chk("high pulse", 32'd500, hi0 - base_hi);
    chk("low pulse", 32'd250, lo1 - base_lo);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(`REG_IRQ_CLR, 32'h0000_0010);
    cyc(3);
    chk("irq clear", 32'h0, {31'h0, irq});
    // Break on full trace memory
    wr(`REG_CTRL, ctrl(1'b1, `MODE_BREAK, 1'b0) | (32'h1 << `CTRL_MEMCLR));
    target_running <= 1'b1;
    cyc(4);
    base_brk = brk;
    for (int i = 0; i < 1030; i++) link.pc_item(3'h1, i);
    cyc(10);
    rd(`REG_STATUS, v, pre[0]);
    chk("mem full", 32'h1, {31'h0, v[`ST_FULL]});
    chk("full break", 32'h1, brk > base_brk);
    rd(`REG_FILL, v, pre[0]);
    chk("mem count held", 32'h0000_03FF, {16'h0, v[31:16]});
    summarize();
  end
endmodule
